// File: include/scl_defs.vh
// Constants for the strap configuration and status indicator block
`ifndef SCL_DEFS_VH
`define SCL_DEFS_VH

// Register offsets (byte addresses)
`define SCL_ADDR_CTRL 8'h00
`define SCL_ADDR_STATE 8'h04
`define SCL_ADDR_SETTINGS 8'h08
`define SCL_ADDR_IRQ_STAT 8'h0c
`define SCL_ADDR_IRQ_MASK 8'h10

// Field positions
`define SCL_CTRL_TARGET_LSB 0
`define SCL_IRQ_DISCARD 0
`define SCL_IRQ_FAULT 1
`define SCL_IRQ_STATE 2
`define SCL_IRQ_W 3

// Reset values
`define SCL_CTRL_RST 2'h0
`define SCL_IRQ_MASK_RST 3'h0

// Fieldbus state codes
`define SCL_CODE_INIT 2'h0
`define SCL_CODE_PREOP 2'h1
`define SCL_CODE_SAFEOP 2'h2
`define SCL_CODE_OP 2'h3

// Level a floating strap stands for
`define SCL_DEF_IFACE_SPI 1'b1
`define SCL_DEF_TEST_MODE 1'b0
`define SCL_DEF_SIZE_16 1'b0
`define SCL_DEF_TIMEOUT_EN 1'b1

// Slave capacity per data size
`define SCL_SLAVES_12B 6'h28
`define SCL_SLAVES_16B 6'h1e

// Timing
`define SCL_CLK_KHZ 100000
`define SCL_TEST_CYCLE_MS 1
`define SCL_FLASH_TIME_MS 50
`define SCL_TIMEOUT_CYCLES 100

`endif

// File: src/scl_top.v
// Strap decoding, fieldbus state tracking and indicator LED driver
//
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "scl_defs.vh"
// Notes on behaviour
// R1: Interface strap low selects USB; high or floating selects serial.
// R2: Mode strap low or floating gives normal mode; high gives test mode.
// R3: Test mode runs to OP alone, IO slaves, 1ms cycle, varying outputs.
// R4: Size strap high gives 16 bytes per slave, otherwise 12 bytes.
// R5: Timeout strap high or floating discards commands over 100 cycles.
// R6: Timeout strap low never limits or discards a command by duration.
// R7: Both status LEDs lit when no slave found or state not reached; code counts no slave only while the target is above Init.
// R8: Status LEDs off in Init/PreOP, yellow SafeOP, green OP.
// R9: Network green flashes on frames; yellow lit at 100 link speed.
// R10: Host uses only one serial connector at a time.
// R11: Busy rises when a transfer starts, falls once processed.
// R12: Capacity is 40 slaves at 12 bytes, 30 slaves at 16 bytes.
// R13: Straps sampled once after reset release, held until next reset.
// R14: A floating strap reads as its default level.
module scl_top #(
    parameter ADDR_W = 8,
    parameter CNT_W = 24,
    parameter CYCLE_CYCLES = `SCL_TEST_CYCLE_MS * `SCL_CLK_KHZ,
    parameter FLASH_CYCLES = `SCL_FLASH_TIME_MS * `SCL_CLK_KHZ,
    parameter TIMEOUT_CYCLES = `SCL_TIMEOUT_CYCLES
) (
    // Clock and reset
    input wire CLK,
    input wire RST_B,
    // Board straps and float sense
    input wire HOST_IFACE_SELECT_STRAP,
    input wire TEST_MODE_STRAP,
    input wire SLAVE_DATA_SIZE_STRAP,
    input wire COMMAND_TIMEOUT_STRAP,
    input wire [3:0] STRAP_FLOAT,
    // Register port
    input wire [ADDR_W-1:0] ADDR,
    input wire [31:0] WR_DATA,
    input wire WR_STB,
    input wire RD_STB,
    output reg [31:0] RD_DATA,
    output reg IRQ,
    // Host command transfer
    input wire CMD_START,
    input wire CMD_DONE,
    output reg BUSY,
    output reg CMD_DISCARD,
    // Fieldbus side
    input wire SLAVES_PRESENT,
    input wire STATE_FAIL,
    input wire FRAME_ACT,
    input wire LINK_100,
    output reg TEST_OUT_STB,
    output reg [7:0] TEST_OUT_DATA,
    // Decoded settings
    output reg USB_SELECT,
    output reg TEST_MODE,
    output reg DATA_SIZE_16,
    output reg TIMEOUT_EN,
    output reg [5:0] MAX_SLAVES,
    // Indicators
    output reg STATUS_LED_YELLOW,
    output reg STATUS_LED_GREEN,
    output reg NET_LED_GREEN,
    output reg NET_LED_YELLOW,
    output reg POWER_LED
);

localparam [3:0] ST_INIT = 4'h1;
localparam [3:0] ST_PREOP = 4'h2;
localparam [3:0] ST_SAFEOP = 4'h4;
localparam [3:0] ST_OP = 4'h8;
localparam integer CYCLE_L = CYCLE_CYCLES - 1;
localparam integer FLASH_L = FLASH_CYCLES - 1;
localparam integer TIMEOUT_L = TIMEOUT_CYCLES - 1;
localparam [CNT_W-1:0] CYCLE_LAST = CYCLE_L[CNT_W-1:0];
localparam [CNT_W-1:0] FLASH_LAST = FLASH_L[CNT_W-1:0];
localparam [7:0] TIMEOUT_LAST = TIMEOUT_L[7:0];
localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};

function [1:0] state_code;
    input [3:0] st;
    begin
        case (st)
            ST_PREOP: state_code = `SCL_CODE_PREOP;
            ST_SAFEOP: state_code = `SCL_CODE_SAFEOP;
            ST_OP: state_code = `SCL_CODE_OP;
            default: state_code = `SCL_CODE_INIT;
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////
// Strap capture

reg sampled_reg;
wire iface_val;
wire test_val;
wire size_val;
wire timeout_val;

// R14: floating as default
assign iface_val = STRAP_FLOAT[0] ? `SCL_DEF_IFACE_SPI
                                  : HOST_IFACE_SELECT_STRAP;
assign test_val = STRAP_FLOAT[1] ? `SCL_DEF_TEST_MODE : TEST_MODE_STRAP;
assign size_val = STRAP_FLOAT[2] ? `SCL_DEF_SIZE_16
                                 : SLAVE_DATA_SIZE_STRAP;
assign timeout_val = STRAP_FLOAT[3] ? `SCL_DEF_TIMEOUT_EN
                                    : COMMAND_TIMEOUT_STRAP;

// Straps are caught by a clock edge after release, never by the reset
always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
        sampled_reg <= 1'b0;
        USB_SELECT <= 1'b0;
        TEST_MODE <= 1'b0;
        DATA_SIZE_16 <= 1'b0;
        TIMEOUT_EN <= 1'b0;
        MAX_SLAVES <= `SCL_SLAVES_12B;
        POWER_LED <= 1'b0;
    end else begin
        POWER_LED <= 1'b1;
        // R13: sample once
        if (!sampled_reg) begin
            sampled_reg <= 1'b1;
            // R1: USB when low
            USB_SELECT <= ~iface_val;
            // R2: test mode when high
            TEST_MODE <= test_val;
            // R4: data size select
            DATA_SIZE_16 <= size_val;
            // R5: limit enable
            TIMEOUT_EN <= timeout_val;
            // R12: slave capacity
            MAX_SLAVES <= size_val ? `SCL_SLAVES_16B : `SCL_SLAVES_12B;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Communication cycle timebase

reg [CNT_W-1:0] cyc_cnt_reg;
reg tick_reg;

always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
        cyc_cnt_reg <= {CNT_W{1'b0}};
        tick_reg <= 1'b0;
    end else begin
        tick_reg <= (cyc_cnt_reg == CYCLE_LAST);
        if (cyc_cnt_reg == CYCLE_LAST)
            cyc_cnt_reg <= {CNT_W{1'b0}};
        else
            cyc_cnt_reg <= cyc_cnt_reg + CNT_ONE;
    end
end

////////////////////////////////////////////////////////////////////////
// Registers and fieldbus state

reg [1:0] target_reg;
reg [`SCL_IRQ_W-1:0] irq_stat_reg;
reg [`SCL_IRQ_W-1:0] irq_mask_reg;
reg [3:0] state_reg;
reg [3:0] state_next;
reg fault_reg;
reg [7:0] to_cnt_reg;
wire [1:0] target;
wire [1:0] cur_code;
wire ctrl_wr;
wire fault_next;
wire timeout_hit;
wire [`SCL_IRQ_W-1:0] irq_set;

assign ctrl_wr = WR_STB && (ADDR == `SCL_ADDR_CTRL);
// R3: test mode heads for OP on its own
assign target = TEST_MODE ? `SCL_CODE_OP : target_reg;
assign cur_code = state_code(state_reg);
// R7: missing slaves with a target above Init, or a failed transition, is a fault
assign fault_next = STATE_FAIL
    || (!SLAVES_PRESENT && sampled_reg && target != `SCL_CODE_INIT)
    || (fault_reg && !ctrl_wr);

// R2: in normal mode the state moves only toward the host's target
always @* begin
    state_next = state_reg;
    if (tick_reg && !fault_reg && sampled_reg) begin
        if (cur_code < target)
            state_next = {state_reg[2:0], 1'b0};
        else if (cur_code > target)
            state_next = {1'b0, state_reg[3:1]};
    end
end

// R5: a command over the limit is dropped; R6: no limit when disabled
assign timeout_hit = BUSY && TIMEOUT_EN && tick_reg
                     && (to_cnt_reg == TIMEOUT_LAST);
assign irq_set = {(state_next != state_reg), fault_next & ~fault_reg,
                  timeout_hit};

always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
        target_reg <= `SCL_CTRL_RST;
        irq_mask_reg <= `SCL_IRQ_MASK_RST;
        irq_stat_reg <= {`SCL_IRQ_W{1'b0}};
        state_reg <= ST_INIT;
        fault_reg <= 1'b0;
        BUSY <= 1'b0;
        CMD_DISCARD <= 1'b0;
        to_cnt_reg <= 8'h00;
        RD_DATA <= 32'h0000_0000;
        IRQ <= 1'b0;
    end else begin
        state_reg <= state_next;
        fault_reg <= fault_next;
        if (ctrl_wr)
            target_reg <= WR_DATA[`SCL_CTRL_TARGET_LSB+1:
                                  `SCL_CTRL_TARGET_LSB];
        if (WR_STB && ADDR == `SCL_ADDR_IRQ_MASK)
            irq_mask_reg <= WR_DATA[`SCL_IRQ_W-1:0];
        // Read clears, but a new event in the same cycle survives
        if (RD_STB && ADDR == `SCL_ADDR_IRQ_STAT)
            irq_stat_reg <= irq_set;
        else
            irq_stat_reg <= irq_stat_reg | irq_set;
        IRQ <= |((irq_stat_reg | irq_set) & irq_mask_reg);
        // R11: busy from transfer start until processed or dropped
        CMD_DISCARD <= timeout_hit;
        if (!BUSY) begin
            to_cnt_reg <= 8'h00;
            if (CMD_START)
                BUSY <= 1'b1;
        end else if (CMD_DONE || timeout_hit) begin
            BUSY <= 1'b0;
        end else if (tick_reg && to_cnt_reg != TIMEOUT_LAST) begin
            to_cnt_reg <= to_cnt_reg + 8'h01;
        end
        // Unmapped reads return zero
        if (RD_STB) begin
            if (ADDR == `SCL_ADDR_CTRL)
                RD_DATA <= {30'h0, target_reg};
            else if (ADDR == `SCL_ADDR_STATE)
                RD_DATA <= {28'h0, BUSY, fault_reg, cur_code};
            else if (ADDR == `SCL_ADDR_SETTINGS)
                RD_DATA <= {18'h0, MAX_SLAVES, 4'h0, TIMEOUT_EN,
                            DATA_SIZE_16, TEST_MODE, USB_SELECT};
            else if (ADDR == `SCL_ADDR_IRQ_STAT)
                RD_DATA <= {29'h0, irq_stat_reg};
            else if (ADDR == `SCL_ADDR_IRQ_MASK)
                RD_DATA <= {29'h0, irq_mask_reg};
            else
                RD_DATA <= 32'h0000_0000;
        end else begin
            RD_DATA <= 32'h0000_0000;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Test pattern, status and network LEDs

reg [CNT_W-1:0] flash_cnt_reg;
reg act_pend_reg;

always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
        TEST_OUT_STB <= 1'b0;
        TEST_OUT_DATA <= 8'h00;
        STATUS_LED_YELLOW <= 1'b0;
        STATUS_LED_GREEN <= 1'b0;
        NET_LED_GREEN <= 1'b0;
        NET_LED_YELLOW <= 1'b0;
        flash_cnt_reg <= {CNT_W{1'b0}};
        act_pend_reg <= 1'b0;
    end else begin
        // R3: new output value to all slaves each cycle once the state is OP
        TEST_OUT_STB <= TEST_MODE && tick_reg && state_reg == ST_OP;
        if (TEST_MODE && tick_reg && state_reg == ST_OP)
            TEST_OUT_DATA <= TEST_OUT_DATA + 8'h01;
        // R7: fault lights both
        if (fault_reg) begin
            STATUS_LED_YELLOW <= 1'b1;
            STATUS_LED_GREEN <= 1'b1;
        end else begin
            // R8: state encoding
            STATUS_LED_YELLOW <= (state_reg == ST_SAFEOP);
            STATUS_LED_GREEN <= (state_reg == ST_OP);
        end
        // R9: link speed and activity flash
        NET_LED_YELLOW <= LINK_100;
        // Frames seen within one flash period keep the LED blinking
        if (FRAME_ACT)
            act_pend_reg <= 1'b1;
        if (flash_cnt_reg == FLASH_LAST) begin
            flash_cnt_reg <= {CNT_W{1'b0}};
            NET_LED_GREEN <= act_pend_reg ? ~NET_LED_GREEN : 1'b0;
            act_pend_reg <= FRAME_ACT;
        end else begin
            flash_cnt_reg <= flash_cnt_reg + CNT_ONE;
        end
    end
end

endmodule // scl_top

// File: sim/scl_properties.sv
// Port-level checks for the strap and indicator block
`timescale 1ns/1ps
module scl_properties (
    // Clock and reset
    input wire CLK,
    input wire RST_B,
    // Command transfer
    input wire CMD_START,
    input wire CMD_DONE,
    input wire BUSY,
    input wire CMD_DISCARD,
    // Settings
    input wire TIMEOUT_EN,
    input wire DATA_SIZE_16,
    input wire [5:0] MAX_SLAVES,
    input wire POWER_LED,
    // Status and network
    input wire STATE_FAIL,
    input wire STATUS_LED_YELLOW,
    input wire STATUS_LED_GREEN,
    input wire NET_LED_YELLOW,
    input wire LINK_100,
    // Register port
    input wire RD_STB,
    input wire [31:0] RD_DATA,
    input wire IRQ
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);
    ////////////////////////////////////////////////////////////////////
    a_busy_rise: assert property (!BUSY && CMD_START |=> BUSY)
        else $error("busy did not rise on start");
    a_busy_fall: assert property (BUSY && CMD_DONE |=> !BUSY)
        else $error("busy did not fall on done");
    a_discard_drop: assert property (
        CMD_DISCARD |-> !BUSY && $past(BUSY))
        else $error("discard without busy drop");
    a_no_limit: assert property (
        POWER_LED && !TIMEOUT_EN |-> !CMD_DISCARD)
        else $error("discard with limit off");
    a_slave_count: assert property (
        MAX_SLAVES == (DATA_SIZE_16 ? 6'h1e : 6'h28))
        else $error("slave count wrong");
    a_settings_hold: assert property (
        $past(POWER_LED) |-> $stable({TIMEOUT_EN, DATA_SIZE_16}))
        else $error("settings moved");
    a_fault_leds: assert property (
        STATE_FAIL |-> ##[2:3] (STATUS_LED_YELLOW && STATUS_LED_GREEN))
        else $error("fault not shown");
    a_link_led: assert property (
        $past(RST_B) |-> NET_LED_YELLOW == $past(LINK_100))
        else $error("link led wrong");
    a_read_idle: assert property (!$past(RD_STB) |-> RD_DATA == 32'h0)
        else $error("read data outside slot");
    c_discard: cover property (CMD_DISCARD);
    c_op_led: cover property (STATUS_LED_GREEN && !STATUS_LED_YELLOW);
    c_irq: cover property (IRQ);
endmodule // scl_properties

// File: sim/scl_partner.sv
// Host controller and board model facing the block
`timescale 1ns/1ps
module scl_partner (
    // Clock and handshake
    input wire clk,
    input wire busy,
    input wire req,
    input wire [7:0] hold,
    input wire quiet,
    // Host outputs
    output reg cmd_start = 1'b0,
    output reg cmd_done = 1'b0,
    output reg frame = 1'b0,
    output reg idle = 1'b1
);
    reg [7:0] cnt_reg = 8'h0;
    reg [2:0] fc_reg = 3'h0;
    always @(posedge clk) begin
        cmd_start <= 1'b0;
        cmd_done <= 1'b0;
        fc_reg <= fc_reg + 3'h1;
        frame <= !quiet && (fc_reg == 3'h0);
        if (idle && req && !busy) begin
            cmd_start <= 1'b1;
            idle <= 1'b0;
            cnt_reg <= 8'h0;
        end else if (!idle) begin
            cnt_reg <= cnt_reg + 8'h1;
            // A slow host may finish after a discard; no done then
            if (cnt_reg == hold) begin
                cmd_done <= busy;
                idle <= 1'b1;
            end
        end
    end
endmodule // scl_partner

// File: sim/scl_top_tb.sv
// Self-checking bench for the strap and indicator block
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module scl_top_tb;
    reg clk = 0, rst_b = 0, wr_stb = 0, rd_stb = 0, req = 0, fail = 0;
    reg slaves = 1, link = 0, quiet = 0, seen, g;
    reg [3:0] strap = 0, flt = 0, s, f;
    reg [7:0] addr = 0, hold = 0;
    reg [31:0] wr_data = 0, seed = 32'h26, d, e;
    wire c_start, c_done, frame, idle, busy, disc, irq, yel, grn, ngrn;
    wire [31:0] rd_data;
    wire usb, tmode, sz16, toen, pwr, nyel, tstb;
    wire [5:0] maxs;
    wire [7:0] tdat;
    int num_errors = 0, n_tests = 0, i, k, t;
    always #5 clk = ~clk;
    scl_top #(.CYCLE_CYCLES(20), .FLASH_CYCLES(8), .TIMEOUT_CYCLES(4)) i_dut (
        .CLK(clk), .RST_B(rst_b), .HOST_IFACE_SELECT_STRAP(strap[0]),
        .TEST_MODE_STRAP(strap[1]), .SLAVE_DATA_SIZE_STRAP(strap[2]),
        .COMMAND_TIMEOUT_STRAP(strap[3]), .STRAP_FLOAT(flt), .ADDR(addr),
        .WR_DATA(wr_data), .WR_STB(wr_stb), .RD_STB(rd_stb),
        .RD_DATA(rd_data), .IRQ(irq), .CMD_START(c_start), .CMD_DONE(c_done),
        .BUSY(busy), .CMD_DISCARD(disc), .SLAVES_PRESENT(slaves),
        .STATE_FAIL(fail), .FRAME_ACT(frame), .LINK_100(link),
        .TEST_OUT_STB(tstb), .TEST_OUT_DATA(tdat), .USB_SELECT(usb),
        .TEST_MODE(tmode), .DATA_SIZE_16(sz16), .TIMEOUT_EN(toen),
        .MAX_SLAVES(maxs),
        .STATUS_LED_YELLOW(yel), .STATUS_LED_GREEN(grn),
        .NET_LED_GREEN(ngrn), .NET_LED_YELLOW(nyel), .POWER_LED(pwr));
    scl_partner i_host (.clk(clk), .busy(busy), .req(req), .hold(hold),
        .quiet(quiet), .cmd_start(c_start), .cmd_done(c_done),
        .frame(frame), .idle(idle));
    ////////////////////////////////////////////////////////////////////
    function [31:0] rnd;
        begin
            seed = seed ^ (seed << 13);
            seed = seed ^ (seed >> 17);
            seed = seed ^ (seed << 5);
            rnd = seed;
        end
    endfunction
    // A floating strap falls back to its default level
    function [31:0] setx(input [3:0] s, input [3:0] f);
        reg [3:0] v;
        begin
            v = (f & 4'b1001) | (~f & s);
            setx = {18'h0, v[2] ? 6'h1e : 6'h28, 4'h0, v[3:1], ~v[0]};
        end
    endfunction
    task end_of_test;
        begin
            $display("comparisons %0d mismatches %0d", n_tests, num_errors);
            if (num_errors == 0 && n_tests > 0) $display("Finished cleanly");
            else $display("Finished with errors");
            $finish;
        end
    endtask
    task wr(input [7:0] a, input [31:0] v);
        begin
            addr <= a; wr_data <= v; wr_stb <= 1; @(posedge clk);
            wr_stb <= 0; @(posedge clk);
        end
    endtask
    task rd(input [7:0] a);
        begin
            addr <= a; rd_stb <= 1; @(posedge clk);
            rd_stb <= 0; #1 d = rd_data; @(posedge clk);
        end
    endtask
    task rst(input [3:0] s, input [3:0] f);
        begin
            rst_b <= 0; strap <= s; flt <= f; repeat (8) @(posedge clk);
            rst_b <= 1; @(posedge clk);
            // Straps move after release; settings must not follow
            strap <= ~s; flt <= ~f;
        end
    endtask
    task cmd(input [7:0] h, input x);
        begin
            hold <= h; req <= 1; @(posedge clk); req <= 0; seen = 0;
            for (i = 0; i < 400 && !(idle && !busy && i > 2); i++) begin
                @(posedge clk); seen = seen | disc;
            end
            if (i == 400) begin num_errors++; end_of_test; end
            else `CHK("discard", x, seen)
        end
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (50000) @(posedge clk);
        num_errors++;
        end_of_test;
    end
    initial begin
        for (k = 0; k < 8; k++) begin
            d = rnd(); {s, f} = d[7:0]; link <= d[8];
            if (k < 3) {s, f} = k == 0 ? 8'h00 : (k == 1 ? 8'h0f : 8'h80);
            rst(s, f); e = setx(s, f);
            wr(8'h08, 32'hffffffff);
            rd(8'h08); `CHK("settings", e, d)
            rd(8'h20); `CHK("unmapped", 32'h0, d)
            d = {maxs, toen, sz16, tmode, usb};
            `CHK("pins", {e[13:8], e[3:0]}, d[9:0])
            `CHK("power link", {1'b1, link}, {pwr, nyel})
            wr(8'h10, 32'h1); cmd(8'd200, e[3]); cmd(8'd2, 1'b0);
            `CHK("irq", e[3], irq)
            rd(8'h0c); `CHK("stat", e[3], d[0])
            repeat (3) @(posedge clk); `CHK("irq clear", 1'b0, irq)
            $display("strap case %0d done", k);
        end
        rst(4'h1, 4'h0);
        for (k = 0; k < 4; k++) begin
            wr(8'h00, k); repeat (100) @(posedge clk);
            `CHK("leds", {k == 2, k == 3}, {yel, grn})
        end
        fail <= 1; @(posedge clk); fail <= 0; repeat (4) @(posedge clk);
        `CHK("fail leds", 2'b11, {yel, grn})
        slaves <= 0; wr(8'h00, 1); repeat (10) @(posedge clk);
        `CHK("no slave leds", 2'b11, {yel, grn})
        slaves <= 1; wr(8'h00, 1); repeat (100) @(posedge clk);
        `CHK("step down", 2'b00, {yel, grn})
        rd(8'h0c); `CHK("events", 2'b11, d[2:1])
        g = ngrn; t = 0;
        repeat (40) begin @(posedge clk); t += (ngrn !== g); g = ngrn; end
        `CHK("net flash", 1'b1, t > 0)
        quiet <= 1; repeat (20) @(posedge clk);
        `CHK("net idle", 1'b0, ngrn)
        rst(4'h2, 4'h0); repeat (100) @(posedge clk);
        `CHK("test mode op", 2'b01, {yel, grn})
        d = tdat; t = 0;
        repeat (45) begin @(posedge clk); t += tstb; end
        `CHK("test outputs", 1'b1, t > 1 && tdat != d[7:0])
        $display("indicator cases done");
        end_of_test;
    end
endmodule // scl_top_tb
bind scl_top scl_properties i_props (.CLK(CLK), .RST_B(RST_B),
    .CMD_START(CMD_START), .CMD_DONE(CMD_DONE), .BUSY(BUSY),
    .CMD_DISCARD(CMD_DISCARD), .TIMEOUT_EN(TIMEOUT_EN),
    .DATA_SIZE_16(DATA_SIZE_16), .MAX_SLAVES(MAX_SLAVES),
    .POWER_LED(POWER_LED), .STATE_FAIL(STATE_FAIL),
    .STATUS_LED_YELLOW(STATUS_LED_YELLOW),
    .STATUS_LED_GREEN(STATUS_LED_GREEN),
    .NET_LED_YELLOW(NET_LED_YELLOW), .LINK_100(LINK_100), .RD_STB(RD_STB),
    .RD_DATA(RD_DATA), .IRQ(IRQ));
